// ==== hw/scl_pkg.sv ====
// Package for the strap and standalone configuration loader.
// Assumes a single 125 MHz clock domain and synchronous active-low reset.
package scl_pkg;

   // ==========================================================
   // Register commands
   localparam logic [7:0] CMD_PIN_STATUS = 8'h11;
   localparam logic [7:0] CMD_OPER_MODE = 8'h12;
   localparam logic [7:0] CMD_DET_CLS_EN = 8'h14;
   localparam logic [7:0] CMD_GLOBAL_RESET = 8'h1a;
   localparam logic [7:0] CMD_POWER_ALLOC = 8'h29;

   // ==========================================================
   // Field positions
   localparam int STANDALONE_BIT = 7;
   localparam int STRAP_LSB = 3;
   localparam int BANK_BIT = 2;
   localparam int GLOBAL_RESET_BIT = 7;
   localparam int PORT_RESET_LSB = 0;

   // ==========================================================
   // Addresses and reset values
   localparam logic [1:0] ADDR_FIXED = 2'h1;
   localparam logic [6:0] ADDR_BROADCAST = 7'h7f;
   localparam logic [7:0] OPER_MODE_RESET = 8'h00;
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam logic [7:0] ALL_ZEROS = 8'h00;

   // ==========================================================
   // Power allocation presets per strap resistor
   localparam logic [7:0] ALLOC_2P15 = 8'h00;
   localparam logic [7:0] ALLOC_2P30 = 8'h33;
   localparam logic [7:0] ALLOC_4P30 = 8'hbb;
   localparam logic [7:0] ALLOC_4P45 = 8'hcc;
   localparam logic [7:0] ALLOC_4P60 = 8'hdd;
   localparam logic [7:0] ALLOC_4P75 = 8'hee;
   localparam logic [7:0] ALLOC_4P90 = 8'hff;

   // Measured mode-select resistor as reported by the analog front end
   typedef enum logic [2:0] {
      STRAP_OPEN, STRAP_124K, STRAP_62K, STRAP_35K7,
      STRAP_22K6, STRAP_15K8, STRAP_11K, STRAP_7K7
   } scl_strap_type;

   // Channel operating mode encodings
   typedef enum logic [1:0] {
      MODE_OFF = 2'h0, MODE_MANUAL = 2'h1, MODE_SEMIAUTO = 2'h2, MODE_AUTO = 2'h3
   } scl_mode_type;

   // Preset bundle loaded at power up
   typedef struct packed {
      logic standalone;
      logic [7:0] oper_mode;
      logic [7:0] det_cls_en;
      logic [7:0] power_alloc;
   } scl_preset_type;

   // Register access from the bus engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] cmd;
      logic [7:0] wdata;
   } scl_req_type;

endpackage : scl_pkg

// ==== hw/scl_preset_decode.sv ====
// Maps the measured mode-select resistor to register presets.
// Assumes the strap code is stable whenever it is sampled.
module scl_preset_decode (
   input wire scl_pkg::scl_strap_type strap,
   output scl_pkg::scl_preset_type preset
);

   wire scl_pkg::scl_preset_type open_set;
   wire [7:0] alloc;

   assign open_set = '{1'b0, scl_pkg::ALL_ZEROS, scl_pkg::ALL_ZEROS, scl_pkg::ALL_ZEROS};
   assign alloc = (strap == scl_pkg::STRAP_124K) ? scl_pkg::ALLOC_2P15 :
                  (strap == scl_pkg::STRAP_62K) ? scl_pkg::ALLOC_2P30 :
                  (strap == scl_pkg::STRAP_35K7) ? scl_pkg::ALLOC_4P30 :
                  (strap == scl_pkg::STRAP_22K6) ? scl_pkg::ALLOC_4P45 :
                  (strap == scl_pkg::STRAP_15K8) ? scl_pkg::ALLOC_4P60 :
                  (strap == scl_pkg::STRAP_11K) ? scl_pkg::ALLOC_4P75 :
                  scl_pkg::ALLOC_4P90;
   // Same allocation for every port
   assign preset = (strap == scl_pkg::STRAP_OPEN) ? open_set :
                   '{1'b1, scl_pkg::ALL_ONES, scl_pkg::ALL_ONES, alloc};

endmodule : scl_preset_decode

// ==== hw/scl_strap_config_loader.sv ====
// Strap and standalone configuration loader for one register bank.
// Assumes a bus engine that presents decoded command accesses and
// a power-up pulse from supply monitoring (both supplies above UVLO).
//
// Behaviour
// - Pin status bit 7 shows standalone
// - Standalone bit shown only in lower bank
// - Bits 6-3 mirror address straps
// - Bank bit is address LSB
// - Answer broadcast address all ones
// - Standalone runs ports with no host
// - Valid resistor: standalone, same allocation everywhere
// - Open pin: disabled, presets all zero
// - 124k: modes on, allocation zeros
// - 62k: allocation 0011 each nibble
// - 35.7k: allocation 1011 each nibble
// - 22.6k: allocation 1100 each nibble
// - 15.8k: allocation 1101 each nibble
// - 11k: allocation 1110 each nibble
// - 7.7k: all three registers ones
// - Higher class demoted to strapped power
// - Bus stays fully usable in standalone
// - Sample resistor only at power up
// - ROM standalone: pin and global resets re-arm; port resets leave ports off
// - SRAM standalone: resets leave ports off
// - Mode register 12h, two bits/channel
// - Mode codes off/manual/semiauto/auto
module scl_strap_config_loader #(
   parameter logic BANK = 1'b0
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic power_up,
   input wire scl_pkg::scl_strap_type mode_select_strap,
   input wire logic [3:0] address_strap_pins,
   input wire logic sram_programmed,
   input wire logic [6:0] bus_address,
   input wire scl_pkg::scl_req_type req,
   input wire logic mode_off_cmd,
   input wire logic [3:0] load_class,
   output logic address_match,
   output logic [7:0] rdata,
   output logic rdata_valid,
   output logic [7:0] channel_operating_mode,
   output logic [7:0] det_cls_enable,
   output logic [7:0] power_allocation,
   output logic standalone_active,
   output logic [3:0] port_run,
   output logic [3:0] granted_class
);

   // ==========================================================
   // Preset decode
   scl_pkg::scl_preset_type preset;

   scl_preset_decode u_decode (
      .strap(mode_select_strap),
      .preset(preset)
   );

   // ==========================================================
   // Address formation
   logic [3:0] strap_address_bits;
   wire channel_bank_select;
   wire [6:0] own_address;

   assign channel_bank_select = BANK;
   assign own_address = {scl_pkg::ADDR_FIXED, strap_address_bits, channel_bank_select};
   assign address_match = (bus_address == own_address) ||
                          (bus_address == scl_pkg::ADDR_BROADCAST);

   // ==========================================================
   // Register access decode
   wire wr_mode;
   wire wr_enable;
   wire wr_alloc;
   wire wr_reset;
   wire global_reset_bit;
   wire [3:0] port_reset_bits;
   wire any_reset;

   assign wr_mode = req.wr && (req.cmd == scl_pkg::CMD_OPER_MODE);
   assign wr_enable = req.wr && (req.cmd == scl_pkg::CMD_DET_CLS_EN);
   assign wr_alloc = req.wr && (req.cmd == scl_pkg::CMD_POWER_ALLOC);
   assign wr_reset = req.wr && (req.cmd == scl_pkg::CMD_GLOBAL_RESET);
   assign global_reset_bit = wr_reset && req.wdata[scl_pkg::GLOBAL_RESET_BIT];
   assign port_reset_bits = wr_reset ? req.wdata[scl_pkg::PORT_RESET_LSB +: 4] : 4'h0;
   assign any_reset = global_reset_bit || !rst_n;

   // ==========================================================
   // Power-up sampling
   logic standalone_q;
   logic [3:0] strap_q;
   logic [7:0] mode_q;
   logic [7:0] mode_d;
   logic [7:0] enable_q;
   logic [7:0] alloc_q;
   logic [7:0] mode_preset_q;
   logic [7:0] enable_preset_q;

   // Straps captured only on power up; reset pin and reset bit leave them
   always_ff @(posedge clock) begin
      if (power_up) begin
         standalone_q <= preset.standalone;
         strap_q <= address_strap_pins;
         mode_preset_q <= preset.oper_mode;
         enable_preset_q <= preset.det_cls_en;
      end
   end

   assign strap_address_bits = strap_q;

   // ==========================================================
   // Channel mode register with per-port off and reset handling
   logic [3:0] port_off;
   logic [7:0] rearm_mask;

   always_comb begin
      mode_d = mode_q;
      port_off = port_reset_bits;
      if (mode_off_cmd || global_reset_bit) begin
         port_off = 4'hf;
      end
      for (int ch = 0; ch < 4; ch++) begin
         if (port_off[ch]) begin
            mode_d[2*ch +: 2] = scl_pkg::MODE_OFF;
         end
      end
      if (wr_mode) begin
         mode_d = req.wdata;
      end
   end

   // ROM build rearms into the strapped preset, SRAM build stays off
   assign rearm_mask = (standalone_q && !sram_programmed) ? mode_preset_q : 8'h00;

   always_ff @(posedge clock) begin
      if (power_up) begin
         mode_q <= preset.oper_mode;
         enable_q <= preset.det_cls_en;
         alloc_q <= preset.power_alloc;
      end else if (any_reset) begin
         mode_q <= scl_pkg::OPER_MODE_RESET | rearm_mask;
         enable_q <= (standalone_q && !sram_programmed) ? enable_preset_q : 8'h00;
      end else begin
         mode_q <= mode_d;
         if (wr_enable) begin
            enable_q <= req.wdata;
         end
         if (wr_alloc) begin
            alloc_q <= req.wdata;
         end
      end
   end

   assign channel_operating_mode = mode_q;
   assign det_cls_enable = enable_q;
   assign power_allocation = alloc_q;
   assign standalone_active = standalone_q;

   // ==========================================================
   // Port activity: automatic mode runs discovery with no host
   for (genvar ch = 0; ch < 4; ch++) begin : g_run
      wire scl_pkg::scl_mode_type channel_mode_pair;
      assign channel_mode_pair = scl_pkg::scl_mode_type'(mode_q[2*ch +: 2]);
      assign port_run[ch] = (channel_mode_pair == scl_pkg::MODE_AUTO) &&
                            enable_q[ch] && enable_q[ch+4];
   end

   // ==========================================================
   // Class demotion against the strapped allocation
   logic [3:0] class_cap;

   always_comb begin
      unique case (alloc_q[3:0])
         4'h0: class_cap = 4'h3;
         4'h3: class_cap = 4'h4;
         4'hb: class_cap = 4'h4;
         4'hc: class_cap = 4'h5;
         4'hd: class_cap = 4'h6;
         4'he: class_cap = 4'h7;
         default: class_cap = 4'h8;
      endcase
   end

   assign granted_class = (load_class > class_cap) ? class_cap : load_class;

   // ==========================================================
   // Read data
   wire [7:0] pin_status;
   wire standalone_shown;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic rvalid_q;

   assign standalone_shown = standalone_q && (channel_bank_select == 1'b0);
   assign pin_status = {standalone_shown, strap_q, channel_bank_select, 2'h0};

   always_comb begin
      unique case (req.cmd)
         scl_pkg::CMD_PIN_STATUS: rdata_d = pin_status;
         scl_pkg::CMD_OPER_MODE: rdata_d = mode_q;
         scl_pkg::CMD_DET_CLS_EN: rdata_d = enable_q;
         scl_pkg::CMD_POWER_ALLOC: rdata_d = alloc_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= req.rd ? rdata_d : rdata_q;
         rvalid_q <= req.rd;
      end
   end

   assign rdata = rdata_q;
   assign rdata_valid = rvalid_q;

endmodule : scl_strap_config_loader

// ==== tb/scl_strap_config_loader_props.sv ====
// Port checker for the strap configuration loader.
// Assumes one clock domain; bound to every loader instance.
module scl_strap_config_loader_props #(
   parameter logic BANK = 1'b0
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic power_up,
   input wire scl_pkg::scl_strap_type mode_select_strap,
   input wire logic [3:0] address_strap_pins,
   input wire logic sram_programmed,
   input wire logic [6:0] bus_address,
   input wire scl_pkg::scl_req_type req,
   input wire logic mode_off_cmd,
   input wire logic address_match,
   input wire logic [7:0] rdata,
   input wire logic rdata_valid,
   input wire logic [7:0] channel_operating_mode,
   input wire logic [7:0] power_allocation,
   input wire logic standalone_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   wire logic [6:0] own_addr = {2'h1, address_strap_pins, BANK};
   wire logic [7:0] pin_exp = {standalone_active & ~BANK, address_strap_pins, BANK, 2'h0};
   // ==========================================================
   // Access sequences
   sequence s_rd_pin;
      req.rd && req.cmd == 8'h11 && !power_up;
   endsequence
   sequence s_wr_mode;
      req.wr && req.cmd == 8'h12;
   endsequence
   // ==========================================================
   // Properties
   a_read_answered: assert property (req.rd |=> rdata_valid)
      else $error("read not answered");
   a_pin_status: assert property (s_rd_pin |=> rdata == $past(pin_exp))
      else $error("pin status wrong");
   a_own_match: assert property (bus_address == own_addr |-> address_match)
      else $error("own address missed");
   a_broadcast_match: assert property (bus_address == 7'h7f |-> address_match)
      else $error("broadcast missed");
   a_mode_write: assert property (s_wr_mode |=> channel_operating_mode == $past(req.wdata))
      else $error("mode write lost");
   a_mode_off: assert property (mode_off_cmd && !req.wr |=> channel_operating_mode == 8'h00)
      else $error("mode off ignored");
   a_open_strap: assert property (power_up && mode_select_strap == scl_pkg::STRAP_OPEN
      |=> !standalone_active && power_allocation == 8'h00)
      else $error("open strap preset wrong");
   a_strap_held: assert property (!power_up |=> $stable(standalone_active))
      else $error("strap resampled");
   a_rom_rearm: assert property ($rose(rst_n) && standalone_active && !sram_programmed
      |-> channel_operating_mode == 8'hff)
      else $error("no rearm after reset");
   a_sram_reset: assert property ($rose(rst_n) && sram_programmed
      |-> channel_operating_mode == 8'h00)
      else $error("ports rearmed with sram");
endmodule : scl_strap_config_loader_props

bind scl_strap_config_loader scl_strap_config_loader_props #(.BANK(BANK)) u_props (
   .clock, .rst_n, .power_up, .mode_select_strap, .address_strap_pins, .sram_programmed,
   .bus_address, .req, .mode_off_cmd, .address_match, .rdata, .rdata_valid,
   .channel_operating_mode, .power_allocation, .standalone_active
);

// ==== tb/scl_host_model.sv ====
// Host bus controller model issuing decoded register accesses.
// Assumes tasks are entered at a falling edge of clock.
module scl_host_model (
   input wire logic clock,
   output scl_pkg::scl_req_type req,
   output logic [6:0] bus_address,
   output logic sram_programmed
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      req = '0;
      bus_address = 7'h00;
      sram_programmed = 1'b0;
   end
   // One access, then released lines show inverted data
   task automatic access(input logic [6:0] a, input logic w, input logic [7:0] c,
                         input logic [7:0] d);
      bus_address = a;
      req = '{wr: w, rd: !w, cmd: c, wdata: d};
      @(negedge clock);
      req = '{wr: 1'b0, rd: 1'b0, cmd: ~c, wdata: ~d};
      @(negedge clock);
   endtask : access
   task automatic load_sram();
      sram_programmed = 1'b1;
   endtask : load_sram
endmodule : scl_host_model

// ==== tb/scl_strap_config_loader_tb.sv ====
// Self-checking bench for the strap configuration loader.
// Assumes the host model drives the bus side; lower bank only.
module scl_strap_config_loader_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic power_up = 1'b0;
   scl_pkg::scl_strap_type mode_select_strap = scl_pkg::STRAP_OPEN;
   logic [3:0] address_strap_pins = 4'h0;
   logic mode_off_cmd = 1'b0;
   logic [3:0] load_class = 4'h8;
   logic sram_programmed, address_match, rdata_valid, standalone_active;
   logic [6:0] bus_address;
   scl_pkg::scl_req_type req;
   logic [7:0] rdata, channel_operating_mode, det_cls_enable, power_allocation;
   logic [3:0] port_run, granted_class;
   int errors = 0;
   int compares = 0;
   logic [7:0] alloc_tab [8] = '{8'h00, 8'h00, 8'h33, 8'hbb, 8'hcc, 8'hdd, 8'hee, 8'hff};
   logic [7:0] cap_tab [8] = '{8'h00, 8'h03, 8'h04, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
   always #4 clock = ~clock;
   scl_host_model host (.clock, .req, .bus_address, .sram_programmed);
   scl_strap_config_loader #(.BANK(1'b0)) dut (
      .clock, .rst_n, .power_up, .mode_select_strap, .address_strap_pins, .sram_programmed,
      .bus_address, .req, .mode_off_cmd, .load_class, .address_match, .rdata, .rdata_valid,
      .channel_operating_mode, .det_cls_enable, .power_allocation, .standalone_active,
      .port_run, .granted_class
   );
   // ==========================================================
   // Helpers
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic rd(input logic [6:0] a, input logic [7:0] c, input logic [7:0] exp);
      fork
         host.access(a, 1'b0, c, 8'h00);
         begin
            @(negedge clock);
            check({7'h0, rdata_valid}, 8'h01);
         end
      join
      check(rdata, exp);
      check({7'h0, rdata_valid}, 8'h00);
   endtask : rd
   task automatic pulse_reset();
      rst_n = 1'b0;
      @(negedge clock);
      rst_n = 1'b1;
      @(negedge clock);
   endtask : pulse_reset
   task automatic end_sim();
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_sim
   // ==========================================================
   // Tests
   initial begin
      repeat (5) @(negedge clock);
      rst_n = 1'b1;
      for (int s = 0; s < 8; s++) begin
         mode_select_strap = scl_pkg::scl_strap_type'(s);
         address_strap_pins = 4'(s * 2 + 1);
         power_up = 1'b1;
         @(negedge clock);
         power_up = 1'b0;
         @(negedge clock);
         check(channel_operating_mode, s ? 8'hff : 8'h00);
         check(det_cls_enable, s ? 8'hff : 8'h00);
         check(power_allocation, alloc_tab[s]);
         check({4'h0, port_run}, s ? 8'h0f : 8'h00);
         if (s != 0)
            check({4'h0, granted_class}, cap_tab[s]);
         rd({2'h1, address_strap_pins, 1'b0}, 8'h11, {s != 0, address_strap_pins, 3'h0});
         check({7'h0, address_match}, 8'h01);
      end
      $display("test straps done");
      mode_select_strap = scl_pkg::STRAP_OPEN;
      host.access(7'h7f, 1'b1, 8'h12, 8'h1b);
      rd(7'h7f, 8'h12, 8'h1b);
      check({7'h0, address_match}, 8'h01);
      host.access(7'h7f, 1'b1, 8'h11, 8'h00);
      rd(7'h7f, 8'h11, {1'b1, address_strap_pins, 3'h0});
      rd(7'h7f, 8'hff, 8'h00);
      host.access(7'h7f, 1'b1, 8'h14, 8'h5a);
      rd(7'h7f, 8'h14, 8'h5a);
      host.access(7'h7f, 1'b1, 8'h29, 8'hc3);
      rd(7'h7f, 8'h29, 8'hc3);
      host.access(7'h7f, 1'b1, 8'h12, 8'hff);
      host.access(7'h7f, 1'b1, 8'h1a, 8'h05);
      check(channel_operating_mode, 8'hcc);
      $display("test bus access done");
      mode_off_cmd = 1'b1;
      @(negedge clock);
      mode_off_cmd = 1'b0;
      check(channel_operating_mode, 8'h00);
      pulse_reset();
      check(channel_operating_mode, 8'hff);
      check({7'h0, standalone_active}, 8'h01);
      host.access(7'h7f, 1'b1, 8'h12, 8'h00);
      host.access(7'h7f, 1'b1, 8'h1a, 8'h80);
      check(channel_operating_mode, 8'hff);
      host.load_sram();
      pulse_reset();
      check(channel_operating_mode, 8'h00);
      $display("test resets done");
      end_sim();
   end
   // Watchdog: about 37 times the expected run
   initial begin
      #20000;
      errors++;
      end_sim();
   end
endmodule : scl_strap_config_loader_tb
